// file: core/wrf_regs.svh
`ifndef WRF_REGS_SVH
`define WRF_REGS_SVH
`define WRF_DATA_W       32
`define WRF_ADDR_W       5
`define WRF_WIN_DEF      8
`define WRF_SET_REGS     16
`define WRF_GLOBALS      8
`define WRF_OUT_BASE     5'h08
`define WRF_LOC_BASE     5'h10
`define WRF_IN_BASE      5'h18
`define WRF_CALL_REG     5'h0F
`define WRF_TRAP_PC_REG  5'h11
`define WRF_TRAP_NPC_REG 5'h12
`define WRF_CWP_RST      5'h00
`define WRF_WIM_RST      32'h0000_0000
`define WRF_CTRL_OFS     8'h00
`define WRF_WIM_OFS      8'h04
`define WRF_STAT_OFS     8'h08
`endif

// file: core/wrf_pkg.sv
package wrf_pkg;
  typedef enum logic [2:0] {
    win_none, win_push, win_pop, win_trap, win_trap_return
  } win_op_t;
  typedef enum logic [1:0] {
    trap_none, trap_overflow, trap_underflow, trap_illegal
  } trap_kind_t;
endpackage

// file: core/wrf_mem_if.sv
interface wrf_mem_if #(parameter int DEPTH = 136, parameter int AW = 8);
  logic [AW-1:0] wa;
  logic          we;
  logic [31:0]   wd;
  logic [AW-1:0] ra_a;
  logic [AW-1:0] ra_b;
  logic [31:0]   rd_a;
  logic [31:0]   rd_b;
  modport ctl (output wa, we, wd, ra_a, ra_b, input rd_a, rd_b);
  modport mem (input wa, we, wd, ra_a, ra_b, output rd_a, rd_b);
endinterface

// file: core/wrf_mem.sv
module wrf_mem #(
  parameter int DEPTH = 136,
  parameter int AW    = 8
) (
  input  wire logic  clk_sys,
  wrf_mem_if.mem     port
);
  logic [31:0] store [DEPTH];

  // ==========================================================
  // Storage, no reset on contents
  always_ff @(posedge clk_sys) begin
    if (port.we) begin
      store[port.wa] <= port.wd;
    end
  end

  always_ff @(posedge clk_sys) begin
    port.rd_a <= store[port.ra_a];
    port.rd_b <= store[port.ra_b];
  end
endmodule

// file: core/windowed_int_register_file.sv
`include "wrf_regs.svh"
// Function
// RL1: 40 to 520 registers of 32 bits
// RL2: 8 globals plus 16-register sets
// RL3: Access globals plus 24-register current window
// RL4: Window is own set plus next ins
// RL5: Window count parameter from 2 to 32
// RL6: Address ranges select ins, locals, outs, globals
// RL7: Window selected by 5-bit pointer
// RL8: Pop and trap return up; push, trap down
// RL9: Overflow and underflow via invalid mask
// RL10: Out o equals o+16 at pointer-1
// RL11: In i equals i-16 at pointer+1
// RL12: Pointer arithmetic wraps modulo window count
// RL13: Windows numbered contiguously from zero
// RL14: Call and link leave pointer unchanged
// RL15: Locals and outs kept across pop then push
// RL16: Doubleword uses even-odd register pair; code writes the even register only
// RL17: Odd doubleword destination raises illegal trap
// RL18: Register zero reads as zero
// RL19: Writes to register zero discarded
// RL20: Call writes own address into r15
// RL21: Trap writes pc, npc into r17, r18
// RL22: Push into invalid window raises overflow
// RL23: Two read ports, one write port
// RL24: Contents not reset, zero register fixed
module windowed_int_register_file #(
  parameter int WINDOW_COUNT = `WRF_WIN_DEF
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic [4:0]    source_reg_field_a,
  input  wire logic [4:0]    source_reg_field_b,
  output logic      [31:0]   read_data_a,
  output logic      [31:0]   read_data_b,
  input  wire logic          wr_en,
  input  wire logic [4:0]    wr_addr,
  input  wire logic [31:0]   wr_data,
  input  wire logic          dword,
  input  wire logic          call_instr,
  input  wire logic          jump_and_link_instr,
  input  wire logic [31:0]   program_counter,
  input  wire logic [31:0]   next_program_counter,
  input  wire wrf_pkg::win_op_t win_op,
  output logic      [4:0]    current_window_pointer,
  output logic               trap_req,
  output wrf_pkg::trap_kind_t trap_kind
);
  localparam int DEPTH = `WRF_GLOBALS + `WRF_SET_REGS * WINDOW_COUNT; // [RL1] [RL2] [RL5]
  localparam int AW    = $clog2(DEPTH);
  localparam logic [4:0] WMAX = 5'(WINDOW_COUNT - 1);

  logic [31:0] window_invalid_mask;
  logic        traps_enabled;
  logic [4:0]  next_cwp;
  logic [4:0]  cwp_up;
  logic [4:0]  cwp_dn;
  logic        zero_a;
  logic        zero_b;
  logic        push_bad;
  logic        pop_bad;
  logic        odd_dw;

  wrf_mem_if #(.DEPTH(DEPTH), .AW(AW)) mif ();

  wrf_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk_sys (clk_sys),
    .port    (mif.mem)
  ); // [RL23]

  // ==========================================================
  // Physical address map
  function automatic logic [AW-1:0] phys(input logic [4:0] r,
                                         input logic [4:0] w);
    logic [4:0] win;
    logic [9:0] base;
    win  = w;
    base = 10'h000;
    if (r < `WRF_OUT_BASE) begin
      phys = AW'(r); // [RL6]
    end else begin
      if (r < `WRF_LOC_BASE) begin
        // Outs are the ins of the window below
        win = (w == 5'h00) ? WMAX : w - 5'h01; // [RL10] [RL12]
      end
      base = 10'(`WRF_GLOBALS) + 10'(win) * 10'(`WRF_SET_REGS); // [RL4]
      // Ins at offset 8, locals at 0 of the set
      if (r >= `WRF_LOC_BASE && r < `WRF_IN_BASE) begin
        phys = AW'(base + 10'(r - `WRF_LOC_BASE));
      end else if (r >= `WRF_IN_BASE) begin
        phys = AW'(base + 10'h008 + 10'(r - `WRF_IN_BASE)); // [RL11]
      end else begin
        phys = AW'(base + 10'h008 + 10'(r - `WRF_OUT_BASE));
      end
    end
  endfunction

  assign cwp_up = (current_window_pointer == WMAX) ? 5'h00
                  : current_window_pointer + 5'h01; // [RL12] [RL13]
  assign cwp_dn = (current_window_pointer == 5'h00) ? WMAX
                  : current_window_pointer - 5'h01;

  assign push_bad = window_invalid_mask[cwp_dn]; // [RL9] [RL22]
  assign pop_bad  = window_invalid_mask[cwp_up]; // [RL9]
  assign odd_dw   = dword & wr_en & wr_addr[0]; // [RL16] [RL17]

  // ==========================================================
  // Window pointer
  always_comb begin
    next_cwp = current_window_pointer;
    case (win_op)
      wrf_pkg::win_push: begin
        if (!push_bad) begin
          next_cwp = cwp_dn; // [RL8]
        end
      end
      wrf_pkg::win_pop: begin
        if (!pop_bad) begin
          next_cwp = cwp_up; // [RL8]
        end
      end
      wrf_pkg::win_trap:        next_cwp = cwp_dn; // [RL8]
      wrf_pkg::win_trap_return: next_cwp = cwp_up; // [RL8]
      default:                  next_cwp = current_window_pointer; // [RL14]
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      current_window_pointer <= `WRF_CWP_RST; // [RL7]
    end else begin
      current_window_pointer <= next_cwp; // [RL3]
    end
  end

  // ==========================================================
  // Trap signalling
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trap_req  <= 1'b0;
      trap_kind <= wrf_pkg::trap_none;
    end else if (win_op == wrf_pkg::win_push && push_bad) begin
      trap_req  <= 1'b1;
      trap_kind <= wrf_pkg::trap_overflow; // [RL22]
    end else if (win_op == wrf_pkg::win_pop && pop_bad) begin
      trap_req  <= 1'b1;
      trap_kind <= wrf_pkg::trap_underflow; // [RL9]
    end else if (odd_dw) begin
      trap_req  <= 1'b1;
      trap_kind <= wrf_pkg::trap_illegal; // [RL17]
    end else begin
      trap_req  <= 1'b0;
      trap_kind <= wrf_pkg::trap_none;
    end
  end

  // ==========================================================
  // Write port, priority trap over call over pipeline
  // A trap writes pc now and npc in the following cycle
  logic        trap_npc_pend;
  logic [31:0] trap_npc_hold;
  logic [4:0]  trap_win;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trap_npc_pend <= 1'b0;
      trap_npc_hold <= 32'h0000_0000;
      trap_win      <= 5'h00;
    end else begin
      trap_npc_pend <= (win_op == wrf_pkg::win_trap);
      trap_npc_hold <= next_program_counter;
      trap_win      <= cwp_dn;
    end
  end

  always_comb begin
    mif.we = 1'b0;
    mif.wa = '0;
    mif.wd = wr_data;
    if (trap_npc_pend) begin
      mif.we = 1'b1;
      mif.wa = phys(`WRF_TRAP_NPC_REG, trap_win); // [RL21]
      mif.wd = trap_npc_hold;
    end else if (win_op == wrf_pkg::win_trap) begin
      mif.we = 1'b1;
      mif.wa = phys(`WRF_TRAP_PC_REG, cwp_dn); // [RL21]
      mif.wd = program_counter;
    end else if (call_instr) begin
      mif.we = 1'b1;
      mif.wa = phys(`WRF_CALL_REG, current_window_pointer); // [RL20]
      mif.wd = program_counter;
    end else if (wr_en && wr_addr != 5'h00 && !odd_dw) begin // [RL19]
      mif.we = 1'b1;
      mif.wa = phys(wr_addr, current_window_pointer); // [RL15]
    end
  end

  // ==========================================================
  // Read ports, one cycle latency
  assign mif.ra_a = phys(source_reg_field_a, current_window_pointer);
  assign mif.ra_b = phys(source_reg_field_b, current_window_pointer);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zero_a <= 1'b1;
      zero_b <= 1'b1;
    end else begin
      zero_a <= (source_reg_field_a == 5'h00); // [RL18]
      zero_b <= (source_reg_field_b == 5'h00);
    end
  end

  assign read_data_a = zero_a ? 32'h0000_0000 : mif.rd_a; // [RL18] [RL24]
  assign read_data_b = zero_b ? 32'h0000_0000 : mif.rd_b;

  // ==========================================================
  // AHB-Lite slave: control, mask, status
  logic       ap_valid;
  logic       ap_write;
  logic [7:0] ap_addr;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      window_invalid_mask <= `WRF_WIM_RST;
      traps_enabled       <= 1'b0;
    end else if (ap_valid && ap_write) begin
      if (ap_addr == `WRF_WIM_OFS) begin
        window_invalid_mask <= hwdata; // [RL9]
      end
      if (ap_addr == `WRF_CTRL_OFS) begin
        traps_enabled <= hwdata[0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      case (haddr[7:0])
        `WRF_CTRL_OFS: hrdata <= {31'h0000_0000, traps_enabled};
        `WRF_WIM_OFS:  hrdata <= window_invalid_mask;
        `WRF_STAT_OFS: hrdata <= {24'h00_0000, trap_req, 2'(trap_kind),
                                  current_window_pointer};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// file: test/wrf_sva.sv
module wrf_chk #(
  parameter int WINDOW_COUNT = 8
) (
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic [4:0]          source_reg_field_a,
  input wire logic [4:0]          source_reg_field_b,
  input wire logic [31:0]         read_data_a,
  input wire logic [31:0]         read_data_b,
  input wire logic                wr_en,
  input wire logic [4:0]          wr_addr,
  input wire logic                dword,
  input wire wrf_pkg::win_op_t    win_op,
  input wire logic [4:0]          current_window_pointer,
  input wire logic                trap_req,
  input wire wrf_pkg::trap_kind_t trap_kind
);
  // ==========================================
  // Pointer arithmetic and checks
  function automatic logic [4:0] up(input logic [4:0] w);
    return 5'((w + 1) % WINDOW_COUNT);
  endfunction
  function automatic logic [4:0] dn(input logic [4:0] w);
    return 5'((w + WINDOW_COUNT - 1) % WINDOW_COUNT);
  endfunction
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_zero_a;
    source_reg_field_a == 5'h00 |=> read_data_a == 32'h0000_0000;
  endproperty
  a_zero_a: assert property (p_zero_a) else $error("r0 port a nonzero");
  property p_zero_b;
    source_reg_field_b == 5'h00 |=> read_data_b == 32'h0000_0000;
  endproperty
  a_zero_b: assert property (p_zero_b) else $error("r0 port b nonzero");
  property p_none;
    win_op == wrf_pkg::win_none |=> $stable(current_window_pointer);
  endproperty
  a_none: assert property (p_none) else $error("pointer moved idle");
  property p_push;
    win_op == wrf_pkg::win_push |=> (trap_req
      && trap_kind == wrf_pkg::trap_overflow
      && $stable(current_window_pointer)) || (!trap_req
      && current_window_pointer == dn($past(current_window_pointer)));
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop;
    win_op == wrf_pkg::win_pop |=> (trap_req
      && trap_kind == wrf_pkg::trap_underflow
      && $stable(current_window_pointer)) || (!trap_req
      && current_window_pointer == up($past(current_window_pointer)));
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_trap;
    win_op == wrf_pkg::win_trap
      |=> current_window_pointer == dn($past(current_window_pointer));
  endproperty
  a_trap: assert property (p_trap) else $error("trap move wrong");
  property p_tret;
    win_op == wrf_pkg::win_trap_return
      |=> current_window_pointer == up($past(current_window_pointer));
  endproperty
  a_tret: assert property (p_tret) else $error("return wrong");
  property p_range;
    current_window_pointer < 5'(WINDOW_COUNT);
  endproperty
  a_range: assert property (p_range) else $error("pointer range");
  property p_odd;
    wr_en && dword && wr_addr[0]
      |=> trap_req && trap_kind == wrf_pkg::trap_illegal;
  endproperty
  a_odd: assert property (p_odd) else $error("odd pair no trap");
endmodule

bind windowed_int_register_file wrf_chk #(.WINDOW_COUNT(WINDOW_COUNT))
  wrf_chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .source_reg_field_a(source_reg_field_a),
  .source_reg_field_b(source_reg_field_b), .read_data_a(read_data_a),
  .read_data_b(read_data_b), .wr_en(wr_en), .wr_addr(wr_addr),
  .dword(dword), .win_op(win_op),
  .current_window_pointer(current_window_pointer),
  .trap_req(trap_req), .trap_kind(trap_kind));

// file: test/iu_model.sv
module iu_model (
  input  wire logic        clk_sys,
  output logic [4:0]       source_reg_field_a,
  output logic [4:0]       source_reg_field_b,
  output logic             wr_en,
  output logic [4:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic             dword,
  output logic             call_instr,
  output logic             jump_and_link_instr,
  output logic [31:0]      program_counter,
  output logic [31:0]      next_program_counter,
  output wrf_pkg::win_op_t win_op,
  input  wire logic [31:0] read_data_a,
  input  wire logic [31:0] read_data_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Pipeline issue and operand read
  initial begin
    win_op = wrf_pkg::win_none;
    {source_reg_field_a, source_reg_field_b} = 10'h000;
    {wr_en, dword, call_instr, jump_and_link_instr} = 4'h0;
    {wr_addr, wr_data, program_counter, next_program_counter} = 101'h0;
  end
  task automatic cyc(input wrf_pkg::win_op_t op, input logic we, dw, cl,
                     input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    win_op <= op;
    jump_and_link_instr <= (op == wrf_pkg::win_none) && !we && !cl;
    {wr_en, dword, call_instr, wr_addr} <= {we, dw, cl, a};
    {wr_data, program_counter, next_program_counter} <= {d, d, ~d};
    @(posedge clk_sys);
    win_op <= wrf_pkg::win_none;
    {wr_en, dword, call_instr, jump_and_link_instr} <= 4'h0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, b, output logic [31:0] da, db);
    @(posedge clk_sys);
    source_reg_field_a <= a;
    source_reg_field_b <= b;
    repeat (2) @(posedge clk_sys);
    #1;
    da = read_data_a;
    db = read_data_b;
  endtask
endmodule

// file: test/windowed_int_register_file_tb.sv
module windowed_int_register_file_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, hsel, hwrite, hready, hreadyout, hresp, wr_en;
  logic dword, call_instr, jump_and_link_instr, trap_req;
  logic [31:0] haddr, hwdata, hrdata, wr_data, read_data_a, read_data_b;
  logic [31:0] program_counter, next_program_counter, r;
  logic [4:0] source_reg_field_a, source_reg_field_b, wr_addr;
  logic [4:0] current_window_pointer;
  logic [2:0] hsize;
  logic [1:0] htrans;
  wrf_pkg::win_op_t win_op;
  wrf_pkg::trap_kind_t trap_kind;
  int errors, n_checks;
  assign hready = hreadyout;
  windowed_int_register_file #(.WINDOW_COUNT(4)) windowed_int_register_file_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .source_reg_field_a(source_reg_field_a), .wr_en(wr_en),
    .source_reg_field_b(source_reg_field_b), .read_data_a(read_data_a),
    .read_data_b(read_data_b), .wr_addr(wr_addr), .wr_data(wr_data),
    .dword(dword), .call_instr(call_instr), .win_op(win_op),
    .jump_and_link_instr(jump_and_link_instr), .trap_req(trap_req),
    .program_counter(program_counter), .trap_kind(trap_kind),
    .next_program_counter(next_program_counter),
    .current_window_pointer(current_window_pointer));
  iu_model iu_model_i (.*);
  // ==========================================
  // Tasks
  task automatic conclude;
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    if (hreadyout !== 1'h1) begin
      errors++;
      conclude();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys);
    {hsel, haddr, htrans, hwrite, hsize} <= {1'h1, a, 2'h2, w, 3'h2};
    rdy();
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
    rdy();
    r = hrdata;
  endtask
  task automatic rr(input logic [4:0] a, b, input logic [31:0] ea, eb);
    logic [31:0] da, db;
    iu_model_i.rd(a, b, da, db);
    chk("port a", ea, da);
    chk("port b", eb, db);
  endtask
  task automatic pw(input logic [4:0] e);
    chk("pointer", {27'h0, e}, {27'h0, current_window_pointer});
  endtask
  task automatic w(input logic dw, input logic [4:0] a, input logic [31:0] d);
    iu_model_i.cyc(wrf_pkg::win_none, 1'h1, dw, 1'h0, a, d);
  endtask
  task automatic op(input wrf_pkg::win_op_t o, input logic cl, input logic [31:0] d);
    iu_model_i.cyc(o, 1'h0, 1'h0, cl, 5'h00, d);
  endtask
  // ==========================================
  // Sequence
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    conclude();
  end
  initial begin
    {rst_b, hsel, hwrite, haddr, hwdata, hsize, htrans} = 72'h0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'h1;
    pw(5'h00);
    ahb(1'h0, 32'h0000_0008, 32'h0);
    chk("status", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, hresp});
    w(1'h0, 5'h00, 32'hFFFF_FFFF);
    rr(5'h00, 5'h00, 32'h0, 32'h0);
    w(1'h0, 5'h03, 32'h1111_1111);
    w(1'h0, 5'h09, 32'h2222_2222);
    w(1'h0, 5'h10, 32'h3333_3333);
    op(wrf_pkg::win_none, 1'h0, 32'h0);
    pw(5'h00);
    op(wrf_pkg::win_push, 1'h0, 32'h0);
    pw(5'h03);
    rr(5'h03, 5'h19, 32'h1111_1111, 32'h2222_2222);
    w(1'h0, 5'h1A, 32'h4444_4444);
    op(wrf_pkg::win_pop, 1'h0, 32'h0);
    op(wrf_pkg::win_pop, 1'h0, 32'h0);
    op(wrf_pkg::win_push, 1'h0, 32'h0);
    pw(5'h00);
    rr(5'h10, 5'h0A, 32'h3333_3333, 32'h4444_4444);
    op(wrf_pkg::win_none, 1'h1, 32'h0000_1000);
    rr(5'h0F, 5'h00, 32'h0000_1000, 32'h0);
    op(wrf_pkg::win_trap, 1'h0, 32'h0000_2000);
    pw(5'h03);
    rr(5'h11, 5'h12, 32'h0000_2000, 32'hFFFF_DFFF);
    op(wrf_pkg::win_trap_return, 1'h0, 32'h0);
    pw(5'h00);
    w(1'h0, 5'h15, 32'h5555_5555);
    w(1'h1, 5'h15, 32'h6666_6666);
    chk("odd trap", 32'h7, {29'h0, trap_req, 2'(trap_kind)});
    w(1'h1, 5'h14, 32'h7777_7777);
    rr(5'h15, 5'h14, 32'h5555_5555, 32'h7777_7777);
    ahb(1'h1, 32'h0000_0004, 32'h0000_0008);
    ahb(1'h0, 32'h0000_0004, 32'h0);
    chk("mask", 32'h0000_0008, r);
    op(wrf_pkg::win_push, 1'h0, 32'h0);
    chk("ovf trap", 32'h5, {29'h0, trap_req, 2'(trap_kind)});
    pw(5'h00);
    ahb(1'h1, 32'h0000_0004, 32'h0);
    ahb(1'h0, 32'h0000_000C, 32'h0);
    chk("unmapped", 32'h0, r);
    conclude();
  end
endmodule
